// [dv/dmcw_far_side.sv]
// Purpose: Model of the internal bus owner seen by one channel.
// Assumes: Grant is a level sampled on clk_in.
// Notes:   A request is granted LAT cycles late; own_in holds the bus.
`timescale 1ns/1ps
module dmcw_far_side #(
  parameter int LAT = 2
) (
  // Clock, reset and bench control.
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic own_in,
  // Ownership handshake.
  input  wire logic bus_request_in,
  output logic      bus_grant_out
);
  int wait_cnt;

  // Late grant on purpose, so the channel must hold its request.
  always @(posedge clk_in) begin
    if (!rst_n_in || !bus_request_in) wait_cnt <= 0;
    else wait_cnt <= wait_cnt + 1;
    bus_grant_out <= rst_n_in && (own_in || (bus_request_in && wait_cnt >= LAT));
  end
endmodule : dmcw_far_side

// [dv/tb_top.sv]
// Purpose: Self-checking bench of the channel mode and wait counter.
// Assumes: Registered outputs; values read just after an edge are the sampled ones.
// Notes:   Table loop for size codes, hand tests for the counter after it.
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 0, rst_n_in = 0, own = 0;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, dv = 0, cf = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, dd = 32'h0;
  logic awr, wr_r, bv, arr, rv, drdy, busy, grant, breq, sgl, toio, stall, irq;
  logic [1:0] br, rr, wresp;
  logic [8:0] opb;
  logic [31:0] rdat;
  int mismatches = 0, num_checks = 0, cyc = 0, n;
  logic [5:0] rc [9] = '{6'h03, 6'h07, 6'h0B, 6'h0F, 6'h13, 6'h17, 6'h1B, 6'h1F, 6'h12};
  logic [10:0] rx [9] = '{11'h007, 11'h00B, 11'h013, 11'h023, 11'h083, 11'h103,
                          11'h003, 11'h403, 11'h080};

  dmcw_channel dmcw_channel_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .s_axi_awvalid_in(awv), .s_axi_awaddr_in(awa), .s_axi_awready_out(awr),
    .s_axi_wvalid_in(wv), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
    .s_axi_wready_out(wr_r), .s_axi_bvalid_out(bv), .s_axi_bresp_out(br),
    .s_axi_bready_in(bre), .s_axi_arvalid_in(arv), .s_axi_araddr_in(ara),
    .s_axi_arready_out(arr), .s_axi_rvalid_out(rv), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rr), .s_axi_rready_in(rre), .desc_valid_in(dv),
    .desc_data_in(dd), .desc_ready_out(drdy), .chain_fetch_in(cf),
    .fetch_busy_out(busy), .bus_grant_in(grant), .bus_request_out(breq),
    .bus_op_bytes_out(opb), .single_addr_out(sgl), .xfer_to_io_out(toio),
    .stall_detect_out(stall), .irq_out(irq));
  dmcw_far_side dmcw_far_side_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .own_in(own),
    .bus_request_in(breq), .bus_grant_out(grant));

  // ************************************************************
  // Clock, timeout and shared tasks.
  // ************************************************************
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  // Each channel is released only at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
    do begin
      @(posedge clk_in);
      if (awr) awv <= 0;
      if (wr_r) wv <= 0;
    end while (!bv);
    wresp = br;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    ara <= a; arv <= 1; rre <= 1;
    do begin
      @(posedge clk_in);
      if (arr) arv <= 0;
    end while (!rv);
    chk(rdat, e);
    chk(rr, re);
  endtask : rd
  // Offers descriptor words in order; valid stays up until the last word is taken.
  task automatic feed(input int first, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      dd <= 32'hA0 + first + i;
      dv <= 1;
      do @(posedge clk_in); while (!drdy);
    end
    dv <= 0;
  endtask : feed
  task automatic release_wait(output int c, input logic w);
    own <= 1;
    repeat (3) @(posedge clk_in);
    own <= 0;
    c = 0;
    do begin
      @(posedge clk_in);
      c++;
    end while ((w ? stall : breq) !== 1'b1 && c < 400);
  endtask : release_wait
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1;
    @(posedge clk_in);
    rd(8'h00, 32'h0, 2'h0);
    wr(8'h08, 32'hFFFF_0000);
    chk(wresp, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    for (int i = 0; i < 9; i++) begin
      wr(8'h00, {26'h0, rc[i]});
      repeat (2) @(posedge clk_in);
      chk({opb, sgl, toio}, rx[i]);
    end
    rd(8'h08, 32'h88, 2'h0);
    wr(8'h08, 32'h8);
    rd(8'h04, 32'h0, 2'h3);
    wr(8'h00, 32'h14);
    rd(8'h08, 32'h88, 2'h0);
    wr(8'h08, 32'h8);
    wr(8'h14, 32'h3);
    wr(8'h00, 32'h0);
    release_wait(n, 0);
    chk(n, 7);
    wr(8'h10, 32'h80);
    wr(8'h00, 32'h3000);
    release_wait(n, 1);
    chk(n >= 128 && n <= 132, 1);
    rd(8'h08, 32'h0002_0200, 2'h0);
    repeat (100) @(posedge clk_in);
    chk({stall, irq}, 2'h3);
    wr(8'h08, 32'h200);
    repeat (2) @(posedge clk_in);
    chk({stall, irq}, 2'h0);
    wr(8'h00, 32'h20);
    feed(0, 8);
    cf <= 1;
    @(posedge clk_in);
    cf <= 0;
    repeat (12) @(posedge clk_in);
    chk(busy, 0);
    for (int i = 0; i < 5; i++) rd(8'h20 + 4 * i, i < 4 ? 32'hA0 + i : 32'h0, 2'h0);
    wr(8'h00, 32'h0);
    cf <= 1;
    @(posedge clk_in);
    cf <= 0;
    feed(8, 4);
    repeat (6) @(posedge clk_in);
    chk(busy, 0);
    for (int i = 0; i < 8; i++) rd(8'h20 + 4 * i, 32'hA4 + i, 2'h0);
    wr(8'h00, 32'h1);
    rst_n_in <= 0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1;
    @(posedge clk_in);
    chk(sgl, 0);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    end_of_test();
  end
endmodule : tb_top

// [rtl/dmcw_channel.sv]
// Purpose: DMA channel mode bits, descriptor loading and wait counter.
// Assumes: AXI4-Lite slave on clk_in at 125 MHz; bus grant is synchronous.
// Notes:   Descriptor words arrive through an 8-word FIFO.
//
// Overview of operation
// R1 - Simple chain loads only four registers.
// R2 - Otherwise descriptor loads all eight registers.
// R3 - Size field decodes bytes per bus operation.
// R4 - Sizes 101 and 111 need single address.
// R5 - Large sizes are ceilings, not exact amounts.
// R6 - Direction bit: 1 memory-to-I/O, 0 I/O-to-memory.
// R7 - Dual address ignores direction bit.
// R8 - Software clears direction for memory fill.
// R9 - Method bit: 1 single, 0 dual, reset 0.
// R10 - I/O mode counter decrements every 64 cycles.
// R11 - I/O mode reload is stall interval over 64.
// R12 - Stall reached: flag, reload, halt counting.
// R13 - Clearing stall flag restarts counting.
// R14 - Memory mode loads delay, decrements every cycle.
// R15 - At zero stop and request the bus.
// R16 - Wait counter read-only, resets to zero.
// R17 - Error enable raises interrupt on stall/error.
// R18 - Stall flag held until write-one clears.
// R19 - Illegal size settings raise configuration error.
`timescale 1ns/1ps
`include "dmcw_consts.svh"
module dmcw_channel
  import dmcw_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // AXI4-Lite write channels.
  input  wire logic        s_axi_awvalid_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  output logic             s_axi_awready_out,
  input  wire logic        s_axi_wvalid_in,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  output logic             s_axi_wready_out,
  output logic             s_axi_bvalid_out,
  output logic [1:0]       s_axi_bresp_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read channels.
  input  wire logic        s_axi_arvalid_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  output logic             s_axi_arready_out,
  output logic             s_axi_rvalid_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  input  wire logic        s_axi_rready_in,
  // Descriptor stream.
  input  wire logic        desc_valid_in,
  input  wire logic [31:0] desc_data_in,
  output logic             desc_ready_out,
  input  wire logic        chain_fetch_in,
  output logic             fetch_busy_out,
  // Internal bus ownership and transfer setup.
  input  wire logic        bus_grant_in,
  output logic             bus_request_out,
  output logic [8:0]       bus_op_bytes_out,
  output logic             single_addr_out,
  output logic             xfer_to_io_out,
  output logic             stall_detect_out,
  output logic             irq_out
);

  typedef struct packed {
    logic                          aw_got;
    logic [7:0]                    aw_addr;
    logic                          w_got;
    logic [31:0]                   w_data;
    logic [3:0]                    w_strb;
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
    logic [13:0]                   ctrl;
    logic [21:0]                   stall_ivl;
    logic [15:0]                   req_delay;
    logic [`DMCW_SLOTS-1:0][31:0]  slot;
    logic                          fetch;
    logic [2:0]                    widx;
    dmcw_wc_state_type             wst;
    logic [15:0]                   wc;
    logic [5:0]                    pre;
    logic                          stall;
    logic                          cfg_err;
    logic                          grant_q;
    logic                          bus_req;
    logic [8:0]                    op_bytes;
    logic                          dir;
    logic                          irq;
  } dmcw_state_type;

  dmcw_state_type st;
  dmcw_state_type next_st;
  logic           fifo_valid;
  logic [31:0]    fifo_data;
  logic           release_ev;
  logic           wr_fire;
  logic           stall_clr;
  logic           stall_set;
  logic           cfg_set;
  logic [31:0]    ctrl_new;
  logic [15:0]    io_reload;
  logic [31:0]    ivl_new;
  logic [31:0]    dly_new;

  // ************************************************************
  // Helpers.
  // ************************************************************

  // Byte-lane merge of a write into an existing word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // R3 size decode
  // R5 sizes are ceilings only
  // A size of four double words or more is only the largest amount per operation; the
  // bus master below may split it, so nothing here counts bytes against it.
  function automatic logic [8:0] size_bytes(input logic [2:0] code);
    logic [8:0] n;
    case (dmcw_size_type'(code))
      SZ_1B:   n = 9'h001;
      SZ_2B:   n = 9'h002;
      SZ_4B:   n = 9'h004;
      SZ_8B:   n = 9'h008;
      SZ_4DW:  n = 9'h020;
      SZ_8DW:  n = 9'h040;
      SZ_32DW: n = 9'h100;
      default: n = 9'h000;
    endcase
    return n;
  endfunction : size_bytes

  // R4 illegal size check
  function automatic logic size_illegal(input logic [13:0] c);
    logic [2:0] sz;
    sz = c[`DMCW_CTL_SIZE_HI:`DMCW_CTL_SIZE_LO];
    return (sz == SZ_BAD) ||
           (!c[`DMCW_CTL_METHOD] && ((sz == SZ_8DW) || (sz == SZ_32DW)));
  endfunction : size_illegal

  // ************************************************************
  // Descriptor FIFO.
  // ************************************************************
  dmcw_fifo #(
    .WIDTH (32),
    .DEPTH (`DMCW_FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (desc_valid_in),
    .in_data_in    (desc_data_in),
    .in_ready_out  (desc_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (st.fetch)
  );

  // Shared decode terms.
  assign release_ev = st.grant_q && !bus_grant_in;
  assign wr_fire    = st.aw_got && st.w_got && !st.bvalid;
  assign stall_clr  = wr_fire && (st.aw_addr == `DMCW_OFS_STATUS) &&
                      st.w_strb[1] && st.w_data[`DMCW_ST_STALL];
  assign ctrl_new   = merge({18'h0, st.ctrl}, st.w_data, st.w_strb) & `DMCW_CTL_MASK;
  // R11 reload is the stall interval divided by 64
  assign io_reload  = st.stall_ivl[21:6];
  // Merged write images of the count fields; a function result cannot be part-selected.
  assign ivl_new    = merge({10'h0, st.stall_ivl}, st.w_data, st.w_strb);
  assign dly_new    = merge({16'h0, st.req_delay}, st.w_data, st.w_strb);

  // ************************************************************
  // Next-state logic.
  // ************************************************************
  always_comb begin
    next_st   = st;
    stall_set = 1'b0;
    cfg_set   = 1'b0;
    next_st.grant_q = bus_grant_in;

    // Write address and data are taken in either order.
    if (s_axi_awvalid_in && st.awready) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && st.wready) begin
      next_st.w_got  = 1'b1;
      next_st.w_data = s_axi_wdata_in;
      next_st.w_strb = s_axi_wstrb_in;
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end

    // Register writes; status bits are write-one-to-clear, wait counter is read-only.
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = `DMCW_RESP_OKAY;
      if (st.aw_addr == `DMCW_OFS_CTRL) begin
        next_st.ctrl = ctrl_new[13:0];
        // R19 flag illegal size
        cfg_set = size_illegal(ctrl_new[13:0]);
      end else if (st.aw_addr == `DMCW_OFS_STATUS) begin
        if (st.w_strb[0] && st.w_data[`DMCW_ST_CFG_ERR]) begin
          next_st.cfg_err = 1'b0;
        end
      end else if (st.aw_addr == `DMCW_OFS_STALL) begin
        next_st.stall_ivl = ivl_new[21:0];
      end else if (st.aw_addr == `DMCW_OFS_DELAY) begin
        next_st.req_delay = dly_new[15:0];
      end else if ((st.aw_addr >= `DMCW_OFS_SLOT0) && (st.aw_addr <= `DMCW_OFS_SLOT7) &&
                   (st.aw_addr[1:0] == 2'h0)) begin
        next_st.slot[st.aw_addr[4:2]] = merge(st.slot[st.aw_addr[4:2]], st.w_data,
                                              st.w_strb);
      end else begin
        next_st.bresp = `DMCW_RESP_DECERR;
      end
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready  = !next_st.w_got && !next_st.bvalid;

    // Read channel: one read at a time, data valid the cycle after the address.
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `DMCW_RESP_OKAY;
      next_st.rdata  = 32'h0000_0000;
      if (s_axi_araddr_in == `DMCW_OFS_CTRL) begin
        next_st.rdata = {18'h0, st.ctrl};
      end else if (s_axi_araddr_in == `DMCW_OFS_STATUS) begin
        // R16 read-only wait counter
        next_st.rdata[31:`DMCW_ST_WC_LO] = st.wc;
        next_st.rdata[`DMCW_ST_STALL]    = st.stall;
        next_st.rdata[`DMCW_ST_ERR_END]  = st.cfg_err;
        next_st.rdata[`DMCW_ST_CFG_ERR]  = st.cfg_err;
      end else if (s_axi_araddr_in == `DMCW_OFS_STALL) begin
        next_st.rdata = {10'h0, st.stall_ivl};
      end else if (s_axi_araddr_in == `DMCW_OFS_DELAY) begin
        next_st.rdata = {16'h0, st.req_delay};
      end else if ((s_axi_araddr_in >= `DMCW_OFS_SLOT0) &&
                   (s_axi_araddr_in <= `DMCW_OFS_SLOT7) &&
                   (s_axi_araddr_in[1:0] == 2'h0)) begin
        next_st.rdata = st.slot[s_axi_araddr_in[4:2]];
      end else begin
        next_st.rresp = `DMCW_RESP_DECERR;
      end
    end
    next_st.arready = !next_st.rvalid;

    // Descriptor fetch: a start pulse is ignored while a fetch runs.
    if (chain_fetch_in && !st.fetch) begin
      next_st.fetch = 1'b1;
      next_st.widx  = 3'h0;
    end else if (st.fetch && fifo_valid) begin
      // R1 simple chain stops after chain, source, destination and count
      // R2 full chain fills all eight slots
      next_st.slot[st.widx] = fifo_data;
      next_st.widx          = st.widx + 3'h1;
      if (st.widx == (st.ctrl[`DMCW_CTL_SIMPLE] ? `DMCW_SIMPLE_LAST : `DMCW_FULL_LAST)) begin
        next_st.fetch = 1'b0;
      end
    end

    // The request is dropped once the channel owns the bus again.
    if (bus_grant_in) begin
      next_st.bus_req = 1'b0;
    end

    // Wait counter sequencing.
    case (st.wst)
      WC_IDLE: begin
        if (release_ev) begin
          next_st.pre = 6'h00;
          if (st.ctrl[`DMCW_CTL_EXT_REQ]) begin
            // R11 reload on release
            next_st.wc  = io_reload;
            next_st.wst = WC_IO;
          end else begin
            // R14 load request delay
            next_st.wc  = st.req_delay;
            next_st.wst = WC_MEM;
          end
        end
      end
      WC_IO: begin
        if (bus_grant_in) begin
          next_st.wst = WC_IDLE;
        end else begin
          // R10 one step per 64 cycles
          next_st.pre = st.pre + 6'h01;
          if (st.pre == `DMCW_PRE_LAST) begin
            if (st.wc <= 16'h0001) begin
              // R12 flag, reload and halt
              stall_set   = 1'b1;
              next_st.wc  = io_reload;
              next_st.wst = WC_STALL;
            end else begin
              next_st.wc = st.wc - 16'h0001;
            end
          end
        end
      end
      WC_STALL: begin
        // R13 clearing the flag restarts detection
        if (stall_clr) begin
          next_st.wc  = io_reload;
          next_st.pre = 6'h00;
          next_st.wst = WC_IO;
        end
      end
      WC_MEM: begin
        if (bus_grant_in) begin
          next_st.wst = WC_IDLE;
        end else if (st.wc == 16'h0000) begin
          // R15 stop and request the bus
          next_st.bus_req = 1'b1;
          next_st.wst     = WC_IDLE;
        end else begin
          // R14 one step per cycle
          next_st.wc = st.wc - 16'h0001;
        end
      end
      default: begin
        next_st.wst = WC_IDLE;
      end
    endcase

    // R18 flag held until cleared; a new stall wins over the clear
    next_st.stall   = (st.stall && !stall_clr) || stall_set;
    // A configuration error in the same cycle as its clear stays set.
    next_st.cfg_err = next_st.cfg_err || cfg_set;

    // R9 method select
    // R6 direction in single address mode
    // R7 dual address ignores direction
    next_st.dir      = st.ctrl[`DMCW_CTL_METHOD] && st.ctrl[`DMCW_CTL_DIR];
    next_st.op_bytes = size_bytes(st.ctrl[`DMCW_CTL_SIZE_HI:`DMCW_CTL_SIZE_LO]);
    // R17 error interrupt
    next_st.irq      = st.ctrl[`DMCW_CTL_ERR_IE] && (st.stall || st.cfg_err);
  end

  // ************************************************************
  // State register.
  // ************************************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st         <= '0;
      st.wst     <= WC_IDLE;
      st.ctrl    <= `DMCW_CTL_RESET;
      st.wc      <= `DMCW_WC_RESET;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register.
  assign s_axi_awready_out = st.awready;
  assign s_axi_wready_out  = st.wready;
  assign s_axi_bvalid_out  = st.bvalid;
  assign s_axi_bresp_out   = st.bresp;
  assign s_axi_arready_out = st.arready;
  assign s_axi_rvalid_out  = st.rvalid;
  assign s_axi_rdata_out   = st.rdata;
  assign s_axi_rresp_out   = st.rresp;
  assign fetch_busy_out    = st.fetch;
  assign bus_request_out   = st.bus_req;
  assign bus_op_bytes_out  = st.op_bytes;
  assign single_addr_out   = st.ctrl[`DMCW_CTL_METHOD];
  assign xfer_to_io_out    = st.dir;
  assign stall_detect_out  = st.stall;
  assign irq_out           = st.irq;

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking dmcw_cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence io_last_tick;
    (st.wst == WC_IO) && (st.pre == 6'h3F) && !bus_grant_in && (st.wc <= 16'h0001);
  endsequence

  sequence io_release;
    (st.wst == WC_IDLE) && release_ev && st.ctrl[`DMCW_CTL_EXT_REQ];
  endsequence

  size_decode_a: assert property ((st.ctrl[4:2] == 3'h4) && $stable(st.ctrl)  // R3
    |-> bus_op_bytes_out == 9'h020) else $error("size decode wrong");
  dual_dir_a: assert property (!st.ctrl[0] && $stable(st.ctrl)  // R7
    |-> !xfer_to_io_out) else $error("direction used in dual mode");
  cfg_illegal_a: assert property ($changed(st.ctrl) && (st.ctrl[4:2] == 3'h6)  // R19
    |-> st.cfg_err) else $error("illegal size not flagged");
  io_tick_a: assert property ((st.wst == WC_IO) && (st.pre == 6'h3F) && !bus_grant_in  // R10
    && (st.wc > 16'h0001) |=> st.wc == $past(st.wc) - 16'h0001) else $error("io tick");
  io_load_a: assert property (io_release  // R11
    |=> (st.wc == $past(io_reload)) && (st.pre == 6'h00)) else $error("io reload wrong");
  stall_set_a: assert property (io_last_tick  // R12
    |=> st.stall && (st.wst == WC_STALL) && (st.wc == $past(io_reload)))
    else $error("stall not detected");
  mem_dec_a: assert property ((st.wst == WC_MEM) && !bus_grant_in && (st.wc != 16'h0000)  // R14
    |=> st.wc == $past(st.wc) - 16'h0001) else $error("memory count step");
  mem_req_a: assert property ((st.wst == WC_MEM) && !bus_grant_in && (st.wc == 16'h0000)  // R15
    |=> bus_request_out && (st.wst == WC_IDLE)) else $error("no bus request");
  stall_hold_a: assert property (st.stall && !stall_clr |=> st.stall)  // R18
    else $error("stall flag lost");
  err_irq_a: assert property (st.ctrl[12] && st.stall |=> irq_out)  // R17
    else $error("missing error interrupt");
  simple_keep_a: assert property (st.fetch && st.ctrl[5] && !wr_fire  // R1
    |=> $stable(st.slot[7:4])) else $error("simple chain wrote high slots");

endmodule : dmcw_channel

// [rtl/dmcw_consts.svh]
// Purpose: Offsets, field positions, reset values and counts of the DMA channel mode block.
// Assumes: 32-bit register bus, one aligned word per register.
// Notes:   Definitions only; included by bare name.
`ifndef DMCW_CONSTS_SVH
`define DMCW_CONSTS_SVH

// ************************************************************
// Register byte offsets.
// ************************************************************
`define DMCW_OFS_CTRL      8'h00
`define DMCW_OFS_STATUS    8'h08
`define DMCW_OFS_STALL     8'h10
`define DMCW_OFS_DELAY     8'h14
`define DMCW_OFS_SLOT0     8'h20
`define DMCW_OFS_SLOT7     8'h3C

// ************************************************************
// Control word fields.
// ************************************************************
`define DMCW_CTL_METHOD    0
`define DMCW_CTL_DIR       1
`define DMCW_CTL_SIZE_LO   2
`define DMCW_CTL_SIZE_HI   4
`define DMCW_CTL_SIMPLE    5
`define DMCW_CTL_ERR_IE    12
`define DMCW_CTL_EXT_REQ   13
`define DMCW_CTL_MASK      32'h0000_303F
`define DMCW_CTL_RESET     14'h0000

// ************************************************************
// Status word fields.
// ************************************************************
`define DMCW_ST_CFG_ERR    3
`define DMCW_ST_ERR_END    7
`define DMCW_ST_STALL      9
`define DMCW_ST_WC_LO      16

// ************************************************************
// Reset values and counts.
// ************************************************************
`define DMCW_WC_RESET      16'h0000
`define DMCW_STALL_RESET   22'h00_0000
`define DMCW_DELAY_RESET   16'h0000
`define DMCW_PRE_LAST      6'h3F
`define DMCW_SLOTS         8
`define DMCW_SIMPLE_LAST   3'h3
`define DMCW_FULL_LAST     3'h7
`define DMCW_FIFO_DEPTH    8
`define DMCW_RESP_OKAY     2'h0
`define DMCW_RESP_DECERR   2'h3

`endif

// [rtl/dmcw_fifo.sv]
// Purpose: Small flop-based FIFO for descriptor words.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   in_ready and out_valid are decoded from the occupancy count flop.
`timescale 1ns/1ps
module dmcw_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Fill side.
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side.
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } dmcw_fifo_state_type;

  dmcw_fifo_state_type st;
  dmcw_fifo_state_type next_st;
  logic                push;
  logic                pop;

  // Flags are decoded from the occupancy count, which is a flop.
  assign in_ready_out  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (st.cnt != '0);
  assign out_data_out  = st.mem[st.rp];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // Pointer and storage update; simultaneous push and pop keep the count.
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data_in;
      next_st.wp         = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : dmcw_fifo

// [rtl/dmcw_pkg.sv]
// Purpose: Types shared by the DMA channel mode block.
// Assumes: Constants come from dmcw_consts.svh.
// Notes:   One-hot wait counter states.
package dmcw_pkg;

  // ************************************************************
  // Wait counter states.
  // ************************************************************
  typedef enum logic [3:0] {
    WC_IDLE  = 4'h1,
    WC_IO    = 4'h2,
    WC_STALL = 4'h4,
    WC_MEM   = 4'h8
  } dmcw_wc_state_type;

  // Bus operation size codes.
  typedef enum logic [2:0] {
    SZ_1B    = 3'h0,
    SZ_2B    = 3'h1,
    SZ_4B    = 3'h2,
    SZ_8B    = 3'h3,
    SZ_4DW   = 3'h4,
    SZ_8DW   = 3'h5,
    SZ_BAD   = 3'h6,
    SZ_32DW  = 3'h7
  } dmcw_size_type;

endpackage : dmcw_pkg
